// >>> bench/dac_input_double_buffer_tb.sv
// self-checking bench for the converter input double buffer
// assumes dacib_top alone, hready looped back from hreadyout_out
module dac_input_double_buffer_tb
  import dacib_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [9:0] val;
    logic [7:0] hi_rd;
    logic [7:0] lo_rd;
  } dacib_row_s;

  localparam dacib_row_s ROWS [3] = '{
    '{8'h01, 8'hA5, 8'hFE, 10'h2A5, 8'h02, 8'hA5},
    '{8'h05, 8'hFF, 8'h96, 10'h25B, 8'h96, 8'hC0},
    '{8'h04, 8'h40, 8'h01, 10'h005, 8'h01, 8'h40}};
  localparam logic [2:0] CODES [5] = '{TRIG_CMP0, TRIG_CMP1,
    TRIG_EXTINT0, TRIG_T1_OVF, TRIG_T1_CAPT};

  logic               clock_in;
  logic               reset_in;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [31:0]        hwdata;
  logic [2:0]         hsize;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic [7:0]         flags;
  logic [VALUE_W-1:0] value;
  logic               enable;
  logic               update;
  logic [31:0]        rd_q;
  logic [9:0]         prev;
  int                 mismatches;
  int                 check_count;
  int                 upd_n;
  int                 n0;
  int                 cycles;

  dacib_top u_dut (
    .clock_in             (clock_in),
    .reset_in             (reset_in),
    .hsel_in              (hsel),
    .haddr_in             (haddr),
    .htrans_in            (htrans),
    .hwrite_in            (hwrite),
    .hsize_in             (hsize),
    .hwdata_in            (hwdata),
    .hready_in            (hreadyout),
    .hrdata_out           (hrdata),
    .hreadyout_out        (hreadyout),
    .hresp_out            (hresp),
    .trigger_flags_in     (flags),
    .converter_value_out  (value),
    .converter_enable_out (enable),
    .shadow_update_out    (update)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
  begin
    if (update === 1'b1)
      upd_n++;
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", n, e, g);
      mismatches++;
    end
  endtask

  // returns at the rising edge where ready is seen, data taken there
  task automatic wait_rdy();
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    rd_q = hrdata;
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h00_0000, d};
    wait_rdy();
  endtask

  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, {24'h00_0000, e}, rd_q);
  endtask

  task automatic settle();
    repeat (2) @(posedge clock_in);
  endtask

  // flag held high three cycles, so only its edge may count
  task automatic pulse(input logic [7:0] m);
    flags <= m;
    repeat (3) @(posedge clock_in);
    flags <= 8'h00;
    repeat (3) @(posedge clock_in);
  endtask

  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata, hsize, flags} = '0;
    {mismatches, check_count, upd_n, cycles} = '0;
    reset_in = 1'b1;
    repeat (3) @(posedge clock_in);
    chk("value", 32'h0, {22'h0, value});
    chk("enable", 32'h0, {31'h0, enable});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    reset_in <= 1'b0;
    @(posedge clock_in);
    rdchk("ctrl", OFS_CTRL, 8'h00);
    rdchk("high", OFS_HIGH, 8'h00);
    rdchk("low", OFS_LOW, 8'h00);
    rdchk("unmapped", 8'h10, 8'h00);
    bus(1'b1, OFS_CTRL, 8'h0E);
    rdchk("ctrl", OFS_CTRL, 8'h04);
    prev = 10'h000;
    foreach (ROWS[i])
    begin
      bus(1'b1, OFS_CTRL, ROWS[i].ctrl);
      bus(1'b1, OFS_LOW, ROWS[i].lo);
      settle();
      chk("value", {22'h0, prev}, {22'h0, value});
      n0 = upd_n;
      bus(1'b1, OFS_HIGH, ROWS[i].hi);
      settle();
      chk("value", {22'h0, ROWS[i].val}, {22'h0, value});
      chk("updates", 32'h1, upd_n - n0);
      chk("enable", {31'h0, ROWS[i].ctrl[0]}, {31'h0, enable});
      rdchk("high", OFS_HIGH, ROWS[i].hi_rd);
      rdchk("low", OFS_LOW, ROWS[i].lo_rd);
      prev = ROWS[i].val;
    end
    bus(1'b1, OFS_CTRL, 8'h01);
    settle();
    chk("value", 32'h005, {22'h0, value});
    bus(1'b1, OFS_HIGH, 8'h03);
    settle();
    chk("value", 32'h340, {22'h0, value});
    prev = 10'h340;
    foreach (CODES[i])
    begin
      bus(1'b1, OFS_CTRL, {1'b1, CODES[i], 4'h1});
      bus(1'b1, OFS_LOW, {5'h02, CODES[i]});
      bus(1'b1, OFS_HIGH, 8'h01);
      settle();
      chk("value", {22'h0, prev}, {22'h0, value});
      pulse(8'h08);
      chk("value", {22'h0, prev}, {22'h0, value});
      n0 = upd_n;
      pulse(8'h01 << CODES[i]);
      prev = {2'b01, 5'h02, CODES[i]};
      chk("value", {22'h0, prev}, {22'h0, value});
      chk("updates", 32'h1, upd_n - n0);
    end
    bus(1'b1, OFS_LOW, 8'h77);
    n0 = upd_n;
    pulse(8'h80);
    chk("value", {22'h0, prev}, {22'h0, value});
    chk("updates", 32'h0, upd_n - n0);
    rdchk("status", OFS_STATUS, 8'h01);
    bus(1'b1, OFS_CTRL, 8'hF5);
    bus(1'b1, OFS_HIGH, 8'hC3);
    rdchk("status", OFS_STATUS, 8'h02);
    n0 = upd_n;
    pulse(8'h80);
    chk("value", 32'h30D, {22'h0, value});
    pulse(8'h80);
    chk("updates", 32'h2, upd_n - n0);
    bus(1'b1, OFS_HIGH, 8'h3C);
    pulse(8'h80);
    chk("value", 32'h0F1, {22'h0, value});
    // reserved code 3 selected: its flag edge must never load
    bus(1'b1, OFS_CTRL, 8'hB1);
    bus(1'b1, OFS_HIGH, 8'h01);
    n0 = upd_n;
    pulse(8'h08);
    chk("value", 32'h0F1, {22'h0, value});
    chk("updates", 32'h0, upd_n - n0);
    // reset in mid-run clears every register again
    reset_in <= 1'b1;
    @(posedge clock_in);
    chk("update", 32'h0, {31'h0, update});
    reset_in <= 1'b0;
    @(posedge clock_in);
    chk("value", 32'h0, {22'h0, value});
    chk("enable", 32'h0, {31'h0, enable});
    rdchk("high", OFS_HIGH, 8'h00);
    rdchk("ctrl", OFS_CTRL, 8'h00);
    chk("hresp", 32'h0, {31'h0, hresp});
    wrap_up();
  end
endmodule

// >>> core/dacib_top.sv
// converter input double buffer with ahb-lite register slave
// assumes one ahb-lite master, word transfers, flags synchronous to clock_in
//
// Operation
// - high and low data bytes are read/write and reset to zero
// - right justified: low holds bits 7..0, high bits 1..0 hold 9..8
// - left justified: high holds bits 9..2, low bits 7..6 hold 1..0
// - the converter is driven from a hidden shadow copy only
// - a low write alone never changes the shadow; it waits for high
// - without auto trigger, writing high loads the shadow at once
// - with auto trigger, selected event loads shadow after low then high
// - eight-bit auto mode: high write alone, then update on every event
// - a justification change reaches the output at the next high write, or with auto trigger at the first event after that high write
// - trigger is a rising edge of the selected flag, enabled or not
// - source codes: 0,1 comparators, 2 ext int, 6 overflow, 7 capture
module dacib_top
  import dacib_pkg::*;
(
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    reset_in,
  // ahb-lite slave
  input  wire logic                    hsel_in,
  input  wire logic [31:0]             haddr_in,
  input  wire logic [1:0]              htrans_in,
  input  wire logic                    hwrite_in,
  input  wire logic [2:0]              hsize_in,
  input  wire logic [31:0]             hwdata_in,
  input  wire logic                    hready_in,
  output logic [31:0]                  hrdata_out,
  output logic                         hreadyout_out,
  output logic                         hresp_out,
  // trigger flags, indexed by source code
  input  wire logic [TRIG_SOURCES-1:0] trigger_flags_in,
  // converter side
  output logic [VALUE_W-1:0]           converter_value_out,
  output logic                         converter_enable_out,
  output logic                         shadow_update_out
);

  dacib_bus_e    bus_r;
  dacib_bus_e    bus_nxt;
  dacib_dphase_s dp_r;
  dacib_dphase_s dp_nxt;
  logic [31:0]   rdata_r;
  logic [31:0]   rdata_nxt;
  logic [31:0]   read_mux;
  logic          addr_ok;

  dacib_ctrl_s   ctrl_r;
  dacib_ctrl_s   ctrl_nxt;
  logic [7:0]    high_r;
  logic [7:0]    high_nxt;
  logic [7:0]    low_r;
  logic [7:0]    low_nxt;
  logic [9:0]    staged_r;
  logic [9:0]    staged_nxt;
  logic [9:0]    shadow_r;
  logic [9:0]    shadow_nxt;
  logic          pend_r;
  logic          pend_nxt;
  logic          armed_r;
  logic          armed_nxt;
  logic          update_r;
  logic          update_nxt;

  logic          wr_en;
  logic          ctrl_wr;
  logic          high_wr;
  logic          low_wr;
  logic [7:0]    high_mask;
  logic [7:0]    low_mask;
  logic [7:0]    wr_byte;
  logic [9:0]    assembled;
  logic          trig_evt;
  logic          load_manual;
  logic          load_auto;

  dacib_trig_edge u_trig (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .flags_in  (trigger_flags_in),
    .select_in (ctrl_r.trigger_source_select),
    .event_out (trig_evt)
  );

  // bus phase tracking; reads take one wait state so hrdata is a flop
  assign addr_ok = hsel_in & hready_in & htrans_in[1];

  always_comb
  begin
    bus_nxt   = bus_r;
    dp_nxt    = dp_r;
    rdata_nxt = rdata_r;
    unique case (bus_r)
      BUS_READ_WAIT:
      begin
        rdata_nxt = read_mux;
        bus_nxt   = BUS_READ_DONE;
      end
      BUS_IDLE, BUS_WRITE, BUS_READ_DONE:
      begin
        if (addr_ok)
        begin
          dp_nxt.write = hwrite_in;
          dp_nxt.addr  = haddr_in[7:0];
          bus_nxt      = hwrite_in ? BUS_WRITE : BUS_READ_WAIT;
        end
        else
        begin
          bus_nxt = BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      bus_r   <= BUS_IDLE;
      dp_r    <= '0;
      rdata_r <= RDATA_RESET;
    end
    else
    begin
      bus_r   <= bus_nxt;
      dp_r    <= dp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hreadyout_out = (bus_r != BUS_READ_WAIT);
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rdata_r;

  // write decode in the data phase
  assign wr_en   = (bus_r == BUS_WRITE);
  assign wr_byte = hwdata_in[7:0];
  assign ctrl_wr = wr_en && (dp_r.addr == OFS_CTRL);
  assign high_wr = wr_en && (dp_r.addr == OFS_HIGH);
  assign low_wr  = wr_en && (dp_r.addr == OFS_LOW);

  // used bit positions follow the current justification
  assign high_mask = ctrl_r.left_justify_select ? LEFT_HIGH_MASK
                                                : RIGHT_HIGH_MASK;
  assign low_mask  = ctrl_r.left_justify_select ? LEFT_LOW_MASK
                                                : RIGHT_LOW_MASK;

  // value built from the high byte being written and the stored low byte
  always_comb
  begin
    if (ctrl_r.left_justify_select)
      assembled = {wr_byte, low_r[7:6]};
    else
      assembled = {wr_byte[1:0], low_r};
  end

  always_comb
  begin
    read_mux = 32'h0000_0000;
    case (dp_r.addr)
      OFS_CTRL:   read_mux[7:0] = ctrl_r;
      OFS_HIGH:   read_mux[7:0] = high_r & high_mask;
      OFS_LOW:    read_mux[7:0] = low_r & low_mask;
      OFS_STATUS:
      begin
        read_mux[STAT_PEND_BIT]  = pend_r;
        read_mux[STAT_ARMED_BIT] = armed_r;
      end
      default:    read_mux = 32'h0000_0000;
    endcase
  end

  // the shadow loads on a high write without auto trigger, or on an armed trigger with it
  assign load_manual = high_wr && !ctrl_r.auto_trigger_enable;
  assign load_auto   = ctrl_r.auto_trigger_enable && trig_evt
                       && armed_r && !pend_r && !high_wr;

  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    high_nxt   = high_r;
    low_nxt    = low_r;
    staged_nxt = staged_r;
    shadow_nxt = shadow_r;
    pend_nxt   = pend_r;
    armed_nxt  = armed_r;
    update_nxt = 1'b0;
    if (ctrl_wr)
      ctrl_nxt = dacib_ctrl_s'(wr_byte & CTRL_WRITE_MASK);
    if (low_wr)
    begin
      low_nxt   = wr_byte & low_mask;
      pend_nxt  = 1'b1;
      armed_nxt = 1'b0;
    end
    if (high_wr)
    begin
      high_nxt   = wr_byte & high_mask;
      staged_nxt = assembled;
      pend_nxt   = 1'b0;
      armed_nxt  = 1'b1;
    end
    if (load_manual)
    begin
      shadow_nxt = assembled;
      update_nxt = 1'b1;
    end
    else if (load_auto)
    begin
      shadow_nxt = staged_r;
      update_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctrl_r   <= dacib_ctrl_s'(CTRL_RESET);
      high_r   <= DATA_RESET;
      low_r    <= DATA_RESET;
      staged_r <= VALUE_RESET;
      shadow_r <= VALUE_RESET;
      pend_r   <= 1'b0;
      armed_r  <= 1'b0;
      update_r <= 1'b0;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      high_r   <= high_nxt;
      low_r    <= low_nxt;
      staged_r <= staged_nxt;
      shadow_r <= shadow_nxt;
      pend_r   <= pend_nxt;
      armed_r  <= armed_nxt;
      update_r <= update_nxt;
    end
  end

  assign converter_value_out  = shadow_r;
  assign converter_enable_out = ctrl_r.converter_enable;
  assign shadow_update_out    = update_r;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  sequence s_read_start;
    addr_ok && !hwrite_in && hreadyout_out;
  endsequence

  sequence s_read_answer;
    !hreadyout_out ##1 hreadyout_out;
  endsequence

  a_read_wait_state: assert property (
    s_read_start |=> s_read_answer)
    else $error("read answer not after one wait state");

  a_low_holds_shadow: assert property (
    low_wr && !load_auto |=> $stable(shadow_r))
    else $error("low write alone changed the shadow");

  a_manual_high_load: assert property (
    high_wr && !ctrl_r.auto_trigger_enable
    |=> shadow_r == $past(assembled) && shadow_update_out)
    else $error("high write did not load shadow in manual mode");

  a_right_mapping: assert property (
    high_wr && !ctrl_r.auto_trigger_enable && !ctrl_r.left_justify_select
    |=> shadow_r == {$past(wr_byte[1:0]), $past(low_r)})
    else $error("right justified mapping wrong");

  a_left_mapping: assert property (
    high_wr && !ctrl_r.auto_trigger_enable && ctrl_r.left_justify_select
    |=> shadow_r == {$past(wr_byte), $past(low_r[7:6])})
    else $error("left justified mapping wrong");

  a_shadow_hidden_load: assert property (
    $changed(shadow_r) |-> $past(load_manual || load_auto))
    else $error("shadow changed without a load");

  a_auto_waits_event: assert property (
    ctrl_r.auto_trigger_enable && !trig_evt |=> $stable(shadow_r))
    else $error("auto mode shadow changed without trigger");

  a_auto_event_loads: assert property (
    ctrl_r.auto_trigger_enable && trig_evt && armed_r && !pend_r
    && !high_wr |=> shadow_r == $past(staged_r) && shadow_update_out)
    else $error("armed trigger did not load shadow");

  a_pending_blocks: assert property (
    pend_r && !high_wr |=> $stable(shadow_r))
    else $error("update while low byte pending");

  a_justify_at_high: assert property (
    $changed(staged_r) |-> $past(high_wr))
    else $error("staged value changed without high write");

  a_unused_read_zero: assert property (
    bus_r == BUS_READ_WAIT && dp_r.addr == OFS_HIGH
    && !ctrl_r.left_justify_select |=> hrdata_out[7:2] == 6'h00)
    else $error("unused high bits read nonzero");

  a_reset_values: assert property (
    $fell(reset_in) |-> high_r == DATA_RESET && low_r == DATA_RESET)
    else $error("data bytes not zero after reset");

endmodule

// >>> core/dacib_trig_edge.sv
// rising-edge detector and selector for the trigger flags
// assumes flag inputs synchronous to clock_in
module dacib_trig_edge
  import dacib_pkg::*;
(
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    reset_in,
  // flags and selection
  input  wire logic [TRIG_SOURCES-1:0] flags_in,
  input  wire logic [2:0]              select_in,
  // selected edge
  output logic                         event_out
);

  logic [TRIG_SOURCES-1:0] prev_r;
  logic [TRIG_SOURCES-1:0] prev_nxt;
  logic [TRIG_SOURCES-1:0] rise;

  genvar gi;
  generate
    for (gi = 0; gi < TRIG_SOURCES; gi++)
    begin : g_src
      assign prev_nxt[gi] = flags_in[gi];
      // reserved codes never fire
      assign rise[gi] = flags_in[gi] & ~prev_r[gi]
                        & TRIG_VALID_MASK[gi];
      always_ff @(posedge clock_in or posedge reset_in)
      begin
        if (reset_in)
          prev_r[gi] <= 1'b0;
        else
          prev_r[gi] <= prev_nxt[gi];
      end
    end
  endgenerate

  assign event_out = rise[select_in];

  a_reserved_quiet: assert property (
    @(posedge clock_in) disable iff (reset_in)
    !TRIG_VALID_MASK[select_in] |-> !event_out)
    else $error("reserved trigger code produced an event");

  // the previous level is taken at today's selection, so a select
  // change never makes a level look like an edge
  a_edge_only: assert property (
    @(posedge clock_in) disable iff (reset_in)
    event_out |-> flags_in[select_in]
    && (($past(flags_in) & (8'h01 << select_in)) == 8'h00))
    else $error("trigger event without rising flag");

endmodule

// >>> include/dacib_pkg.sv
// constants, field layouts and types of the converter input double buffer
// assumes an ahb-lite master with 32-bit data and word transfers only
package dacib_pkg;

  localparam int VALUE_W = 10;

  // byte addresses of the register words
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_HIGH   = 8'h04;
  localparam logic [7:0] OFS_LOW    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [9:0]  VALUE_RESET  = 10'h000;
  localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

  // writable bits of the control word: 7..4, 2, 0
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hF5;

  // used bits of the data bytes per justification
  localparam logic [7:0] RIGHT_HIGH_MASK = 8'h03;
  localparam logic [7:0] RIGHT_LOW_MASK  = 8'hFF;
  localparam logic [7:0] LEFT_HIGH_MASK  = 8'hFF;
  localparam logic [7:0] LEFT_LOW_MASK   = 8'hC0;

  // status word bit positions
  localparam int STAT_PEND_BIT  = 0;
  localparam int STAT_ARMED_BIT = 1;

  // trigger source codes
  localparam logic [2:0] TRIG_CMP0     = 3'h0;
  localparam logic [2:0] TRIG_CMP1     = 3'h1;
  localparam logic [2:0] TRIG_EXTINT0  = 3'h2;
  localparam logic [2:0] TRIG_T1_OVF   = 3'h6;
  localparam logic [2:0] TRIG_T1_CAPT  = 3'h7;
  localparam int         TRIG_SOURCES  = 8;
  localparam logic [7:0] TRIG_VALID_MASK = 8'hC7;

  typedef struct packed {
    logic       auto_trigger_enable;
    logic [2:0] trigger_source_select;
    logic       rsv3;
    logic       left_justify_select;
    logic       rsv1;
    logic       converter_enable;
  } dacib_ctrl_s;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
  } dacib_dphase_s;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT,
    BUS_READ_DONE
  } dacib_bus_e;

endpackage
